/* verilog/sample_frame_pkg.sv */
// Constants for the serial sample frame block.
// Assumes a 20 MHz system clock sampling the frame pins.
package sample_frame_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS            = 50;
  localparam int OUTPUT_ENABLE_DELAY_NS   = 20;
  localparam int BIT_ACCESS_DELAY_NS      = 40;
  localparam int TRACK_TIME_MIN_NS        = 350;
  localparam int WAKE_DELAY_NS            = 1000;
  localparam int OUTPUT_ENABLE_DELAY_CYC  =
    (OUTPUT_ENABLE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : OUTPUT_ENABLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int BIT_ACCESS_DELAY_CYC     =
    (BIT_ACCESS_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : BIT_ACCESS_DELAY_NS / CLK_PERIOD_NS;
  localparam int TRACK_TIME_MIN_CYC       =
    (TRACK_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int RESULT_WIDTH             = 12;
  localparam int LEAD_ZEROS               = 3;
  localparam logic [4:0] HOLD_END_RISE    = 5'h0_D;
  localparam logic [4:0] FRAME_END_FALL   = 5'h1_0;
  localparam logic [15:0] SHIFT_RESET     = 16'h0000;
endpackage

/* verilog/pin_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to CLK_I.
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic init_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;
  // ----------------------------------------
  // Stages
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    // Start at the idle level so release shows no false edge
    if (!rst_n_i) begin
      s1 <= init_i;
      s2 <= init_i;
      s3 <= init_i;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Only an agreed value counts, rejecting a single-sample glitch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_o <= init_i;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end
endmodule

/* verilog/sample_frame.sv */
// Frame control of a serial read port for a 12-bit sampling converter.
// Assumes the controller drives frame select and serial clock as async pins.
module sample_frame (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        FRAME_SEL_N_I,
  input  wire logic        SERIAL_CLK_I,
  input  wire logic [11:0] SAMPLE_CODE_I,
  output logic             SAMPLE_HOLD_O,
  output logic             SERIAL_RESULT_OUT_O,
  output logic             SERIAL_RESULT_OE_O
);
  typedef enum logic [1:0] {IDLE, HOLD, TRACK} phase_type;

  logic        sel_n;
  logic        sclk;
  logic        sel_n_d;
  logic        sclk_d;
  logic        frame_start;
  logic        frame_stop;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [4:0]  rise_cnt;
  logic [4:0]  fall_cnt;
  logic [15:0] shift;
  phase_type   phase;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  // True on the edge that brings a count to its limit
  function automatic logic at_last_edge(input logic [4:0] cnt, input logic [4:0] limit);
    at_last_edge = (cnt == limit - 5'h0_1);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync u_sel (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (FRAME_SEL_N_I),
    .init_i  (1'b1),
    .level_o (sel_n)
  );
  pin_sync u_sclk (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   (SERIAL_CLK_I),
    .init_i  (1'b0),
    .level_o (sclk)
  );

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sel_n_d <= 1'b1;
      sclk_d  <= 1'b0;
    end else begin
      sel_n_d <= sel_n;
      sclk_d  <= sclk;
    end
  end

  assign frame_start = sel_n_d & ~sel_n;
  assign frame_stop  = ~sel_n_d & sel_n;
  assign sclk_rise   = ~sclk_d & sclk & ~sel_n;
  assign sclk_fall   = sclk_d & ~sclk & ~sel_n;

  // ----------------------------------------
  // Edge counters
  // ----------------------------------------
  // Counts saturate so extra clocks in a long frame do nothing
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rise_cnt <= 5'h0_0;
      fall_cnt <= 5'h0_0;
    end else if (frame_start) begin
      rise_cnt <= 5'h0_0;
      fall_cnt <= 5'h0_0;
    end else begin
      if (sclk_rise && rise_cnt != 5'h1_F) begin
        rise_cnt <= rise_cnt + 5'h0_1;
      end
      if (sclk_fall && fall_cnt != 5'h1_F) begin
        fall_cnt <= fall_cnt + 5'h0_1;
      end
    end
  end

  // ----------------------------------------
  // Track and hold
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      phase         <= IDLE;
      SAMPLE_HOLD_O <= 1'b0;
    end else begin
      case (phase)
        IDLE, TRACK: begin
          if (frame_start) begin
            phase         <= HOLD;
            SAMPLE_HOLD_O <= 1'b1;
          end
        end
        HOLD: begin
          if (sclk_rise && at_last_edge(rise_cnt, sample_frame_pkg::HOLD_END_RISE)) begin
            phase         <= TRACK;
            SAMPLE_HOLD_O <= 1'b0;
          end
        end
        default: begin
          phase         <= IDLE;
          SAMPLE_HOLD_O <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Bit 15 is the first bit shown; falls shift the next one up
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      shift <= sample_frame_pkg::SHIFT_RESET;
    end else if (frame_start) begin
      shift <= {4'h0, SAMPLE_CODE_I};
    end else if (sclk_fall) begin
      shift <= {shift[14:0], 1'b0};
    end
  end

  // Bit 15 is zero after reset or a full frame; falls one to three show the lead zeros,
  // so a receiver capturing on the next fall sees three zeros then data
  assign SERIAL_RESULT_OUT_O = shift[15];

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      SERIAL_RESULT_OE_O <= 1'b0;
    end else if (frame_start) begin
      SERIAL_RESULT_OE_O <= 1'b1;
    end else if (frame_stop) begin
      SERIAL_RESULT_OE_O <= 1'b0;
    end else if (sclk_fall &&
                 at_last_edge(fall_cnt, sample_frame_pkg::FRAME_END_FALL)) begin
      SERIAL_RESULT_OE_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence frame_begins;
    frame_start;
  endsequence
  sequence output_up;
    SERIAL_RESULT_OE_O && SAMPLE_HOLD_O;
  endsequence

  AST_START_HOLDS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_begins |=> output_up)
    else $error("hold or enable missing after frame start");
  AST_ENABLE_FAST: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_start |-> ##[1:1] SERIAL_RESULT_OE_O)
    else $error("output enable late");
  AST_TRACK_13: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (sclk_rise && rise_cnt == 5'h0_C && SAMPLE_HOLD_O && !frame_start) |=> !SAMPLE_HOLD_O)
    else $error("hold not ended on thirteenth rise");
  AST_HOLD_KEEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (SAMPLE_HOLD_O && rise_cnt < 5'h0_C && !frame_start) |=> SAMPLE_HOLD_O)
    else $error("hold ended early");
  AST_RELEASE_16: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (sclk_fall && fall_cnt == 5'h0_F && !frame_start) |=> !SERIAL_RESULT_OE_O)
    else $error("output not released on sixteenth fall");
  AST_RELEASE_SEL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_stop |=> !SERIAL_RESULT_OE_O)
    else $error("output not released on frame select rise");
  AST_LEAD_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (SERIAL_RESULT_OE_O && fall_cnt < 5'h0_3) |-> !SERIAL_RESULT_OUT_O)
    else $error("leading zero bit not zero");
  AST_BIT_STEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (sclk_fall && !frame_start) |=> SERIAL_RESULT_OUT_O == $past(shift[14]))
    else $error("bit not advanced on fall");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  sequence sel_idle;
    sel_n && sel_n_d;
  endsequence

  AST_QUIET_IDLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sel_idle |-> !SERIAL_RESULT_OE_O)
    else $error("output driven while frame select high");
  AST_CODE_LOAD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_begins |=> (shift[15:12] == 4'h0 && shift[11:0] == $past(SAMPLE_CODE_I)))
    else $error("sample code not loaded at frame start");
  AST_FIRST_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_begins |=> !SERIAL_RESULT_OUT_O)
    else $error("first bit not zero");
  AST_COUNT_CLEAR: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    frame_begins |=> (rise_cnt == 5'h0_0 && fall_cnt == 5'h0_0))
    else $error("edge counts not cleared at frame start");
  AST_TRACK_STAYS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!SAMPLE_HOLD_O && !frame_start) |=> !SAMPLE_HOLD_O)
    else $error("hold entered without frame start");
  AST_EDGES_IGNORED: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sel_n |=> ($stable(rise_cnt) && $stable(fall_cnt)))
    else $error("serial edge counted while frame select high");
  AST_RELEASE_STAYS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!SERIAL_RESULT_OE_O && !frame_start) |=> !SERIAL_RESULT_OE_O)
    else $error("output driven again without frame start");
endmodule

/* bench/frame_master.sv */
// Serial port controller model: frames select and clock, captures bits.
// Assumes the block under test answers within a few system clocks.
module frame_master (
  input  wire logic        start_i,
  input  wire logic [4:0]  falls_i,
  input  wire logic        hold_i,
  input  wire logic        data_i,
  input  wire logic        oe_i,
  output logic             sel_n_o,
  output logic             sclk_o,
  output logic [14:0]      word_o,
  output logic [3:0]       flags_o,
  output logic             done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b1;
    word_o  = '0;
    flags_o = '0;
    done_o  = 1'b0;
  end
  // Odd offset keeps the link unrelated in phase to the system clock
  always @(posedge start_i) begin
    done_o = 1'b0;
    word_o = '0;
    flags_o = '0;
    #13 sel_n_o = 1'b0;
    #300;
    for (int i = 1; i <= falls_i; i++) begin
      // A released line reads as the inverse of the last bit shown
      if (i >= 2) word_o = {word_o[13:0], oe_i ? data_i : ~data_i};
      if (i == 2) flags_o[0] = oe_i;
      sclk_o = 1'b0;
      #200;
      if (i == 13) flags_o[1] = hold_i;
      if (i == 14) flags_o[2] = hold_i;
      sclk_o = 1'b1;
      #200;
    end
    if (falls_i != 5'h1_0) sel_n_o = 1'b1;
    #400 flags_o[3] = oe_i;
    sel_n_o = 1'b1;
    #400 done_o = 1'b1; // Gap well over the acquisition minimum
  end
endmodule

/* bench/sample_frame_tb.sv */
// Self-checking bench for the serial sample frame block.
// Assumes the controller model drives both frame pins.
module sample_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        start    = 1'b0;
  logic [4:0]  falls    = 5'h0_0;
  logic [11:0] code     = 12'h000;
  logic        sel_n;
  logic        sclk;
  logic        hold;
  logic        dout;
  logic        oe;
  logic        done;
  logic [14:0] word;
  logic [3:0]  flags;
  int          failures = 0;
  int          n_tests  = 0;
  int          cycles   = 0;
  always #25 clk = ~clk;
  sample_frame dut (.CLK_I(clk), .RST_N_I(rst_n), .FRAME_SEL_N_I(sel_n),
    .SERIAL_CLK_I(sclk), .SAMPLE_CODE_I(code), .SAMPLE_HOLD_O(hold),
    .SERIAL_RESULT_OUT_O(dout), .SERIAL_RESULT_OE_O(oe));
  frame_master master (.start_i(start), .falls_i(falls), .hold_i(hold),
    .data_i(dout), .oe_i(oe), .sel_n_o(sel_n), .sclk_o(sclk),
    .word_o(word), .flags_o(flags), .done_o(done));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic run(input logic [11:0] c, input logic [4:0] n);
    code  <= c;
    falls <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 400 && done !== 1'b1; k++) @(posedge clk);
    if (done !== 1'b1) begin
      $display("mismatch done expected 1 seen %b", done);
      failures++;
      wrap_up();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic full_frame(input logic [11:0] c);
    run(c, 5'h1_0);
    check("word", {4'h0, c}, {1'b0, word});
    check("oe_start", 16'h0001, {15'h0000, flags[0]});
    check("hold_12", 16'h0001, {15'h0000, flags[1]});
    check("hold_13", 16'h0000, {15'h0000, flags[2]});
    check("oe_end", 16'h0000, {15'h0000, flags[3]});
  endtask
  task automatic abort_frame();
    run(12'hC3C, 5'h0_5);
    check("word_part", 16'h0001, {12'h000, word[3:0]});
    check("oe_abort", 16'h0000, {15'h0000, flags[3]});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (sample_frame_pkg::WAKE_DELAY_NS / sample_frame_pkg::CLK_PERIOD_NS)
      @(posedge clk);
    check("idle", 16'h0000, {14'h0000, hold, oe});
    full_frame(12'hA5C);
    full_frame(12'hFFF);
    full_frame(12'h000);
    abort_frame();
    full_frame(12'h801);
    wrap_up();
  end
endmodule
